//--- pkg/srvq_regs.svh
// Register map, field positions and timing constants of the servo PWM and quadrature block.
// Operation
// [RULE1] With the watchdog enabled, all pins float once host traffic stops for about 6.5 ms.
// [RULE2] Pins float before configuration and after an orderly host shutdown.
// [RULE3] Direction output is high for negative commands, reversed by the polarity flip bit.
// [RULE4] Each index input raises its index event on a rising edge of the filtered level.
// [RULE5] Encoder inputs are sampled every 25 ns and pulses under seven samples are rejected; the code samples every 3 cycles, 24 ns.
// [RULE6] Status LED shows increase_drive xor decrease_drive of channel 0.
// [RULE7] Four counters decode every edge of both phases, 4x decoding.
// [RULE8] Counters are wide enough for 8191 counts between host reads.
// [RULE9] Each PWM takes a signed duty with 4095 levels from -100 to +100 percent.
// [RULE10] The PWM period is 2047 clock cycles.
// [RULE11] Each generator also offers a selectable pulse-density mode.
// [RULE12] Pulse-direction style puts the PWM pulse on increase_drive, else the up signal.
// [RULE13] Pulse-direction style puts direction on decrease_drive, else the down signal.
// [RULE14] There are 18 digital outputs, 10 dedicated and 8 on the PWM pins.
// [RULE15] Each shared PWM pin carries PWM xor its paired digital output.
// [RULE16] The polarity flip bit of a shared output makes that pin active low.
// [RULE17] There are 20 digital inputs, 12 of them reading the filtered encoder pins.
// [RULE18] Index pins read as inputs 8-11, phase A as 12-15, phase B as 16-19.
// [RULE19] All host exchange runs as bus transactions with the host.
// [RULE20] Outputs 0-9 update together; shared outputs update with their channel's duty.
// [RULE21] All 20 inputs latch at one instant per read; counts and duties independently.
// [RULE22] Counters run freely and wrap; the host computes deltas.
// [RULE23] Any host write restarts the watchdog interval.
`ifndef SRVQ_REGS_SVH
`define SRVQ_REGS_SVH

`define SRVQ_A_CTRL      12'h000
`define SRVQ_A_DOUT      12'h004
`define SRVQ_A_FLIP      12'h008
`define SRVQ_A_DIN       12'h00c
`define SRVQ_A_STAT      12'h010
`define SRVQ_A_DUTY      12'h020
`define SRVQ_A_COUNT     12'h030

`define SRVQ_B_OUTEN     0
`define SRVQ_B_WDEN      1
`define SRVQ_B_PDS       4
`define SRVQ_B_PDM       8
`define SRVQ_B_IDX       16
`define SRVQ_CTRL_RST    12'h002

`define SRVQ_CLK_MHZ     125
`define SRVQ_SAMPLE_NS   25
`define SRVQ_SAMPLE_CYC  ((`SRVQ_SAMPLE_NS * `SRVQ_CLK_MHZ) / 1000)
`define SRVQ_FILT_NS     175
`define SRVQ_FILT_N      3'h7
`define SRVQ_PWM_PERIOD  11'h7ff
`define SRVQ_WD_NS       6500000
`define SRVQ_WD_CYCLES   ((`SRVQ_WD_NS * `SRVQ_CLK_MHZ) / 1000)

`endif

//--- pkg/srvq_pkg.sv
// Types shared by the servo PWM and quadrature block.
package srvq_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } srvq_apb_req_t;

   typedef struct packed {
      logic       led;
      logic [9:0] dout;
      logic [3:0] dec;
      logic [3:0] inc;
   } srvq_pins_t;
endpackage

//--- rtl/srvq_top.sv
// Four-channel PWM, quadrature counter and digital I/O block with an APB register slave.
`timescale 1ns/1ps
`include "srvq_regs.svh"
module srvq_top #(
   parameter int WD_CYCLES = `SRVQ_WD_CYCLES,
   parameter int NCH       = 4,
   parameter int CNT_W     = 14
) (
   // Clock, reset and enable.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  ce,
   // APB slave.
   input  wire srvq_pkg::srvq_apb_req_t apb_req,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Input pins.
   input  wire logic [7:0]            dedicated_input,
   input  wire logic [3:0]            encoder_phase_a,
   input  wire logic [3:0]            encoder_phase_b,
   input  wire logic [3:0]            encoder_index,
   // Output pins and their enables.
   output srvq_pkg::srvq_pins_t       pins,
   output srvq_pkg::srvq_pins_t       pins_oe
);
   import srvq_pkg::*;

   localparam int WDW = $clog2(WD_CYCLES + 1);
   localparam int SCW = $clog2(`SRVQ_SAMPLE_CYC + 1);

   logic [11:0]      ctrl_q;
   logic [17:0]      dout_q;
   logic [17:0]      flip_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic [WDW-1:0]   wd_cnt_q;
   logic             wd_exp_q;
   logic [SCW-1:0]   tcnt_q;
   logic [10:0]      pcnt_q;
   logic [11:0]      filt_q;
   logic [2:0]       fcnt_w [12];
   logic [CNT_W-1:0] cnt_w [NCH];
   logic [NCH-1:0]   idx_w;
   logic [NCH-1:0]   inc_w;
   logic [NCH-1:0]   dec_w;
   logic [NCH-1:0]   neg_w;
   logic [NCH-1:0]   duty_we;
   logic [NCH-1:0]   idx_clr;
   srvq_pins_t       pins_q;
   srvq_pins_t       pins_oe_q;
   srvq_pins_t       pins_d;

   // Bus phase decode and address match.
   wire              setup    = apb_req.psel & ~apb_req.penable; // RULE19
   wire              wr_en    = apb_req.psel & apb_req.penable & pready_q & apb_req.pwrite;
   wire [11:0]       a        = apb_req.paddr;
   wire [11:0]       duty_base = `SRVQ_A_DUTY;
   wire [11:0]       cnt_base  = `SRVQ_A_COUNT;
   wire [1:0]        ch_sel   = a[3:2];
   wire              hit_duty = (a[11:4] == duty_base[11:4]) && (a[1:0] == 2'h0);
   wire              hit_cnt  = (a[11:4] == cnt_base[11:4]) && (a[1:0] == 2'h0);
   wire              hit_ctrl = (a == `SRVQ_A_CTRL);
   wire              hit_dout = (a == `SRVQ_A_DOUT);
   wire              hit_flip = (a == `SRVQ_A_FLIP);
   wire              hit_din  = (a == `SRVQ_A_DIN);
   wire              hit_stat = (a == `SRVQ_A_STAT);
   wire              hit      = hit_duty | hit_cnt | hit_ctrl | hit_dout | hit_flip | hit_din | hit_stat;

   // Control fields and pin release.
   wire              out_en   = ctrl_q[`SRVQ_B_OUTEN];
   wire              wd_en    = ctrl_q[`SRVQ_B_WDEN];
   wire [3:0]        pds      = ctrl_q[`SRVQ_B_PDS +: 4];
   wire [3:0]        pdm      = ctrl_q[`SRVQ_B_PDM +: 4];
   wire              pins_en  = out_en & ~(wd_en & wd_exp_q); // RULE1 RULE2
   wire              tick     = (tcnt_q == SCW'(`SRVQ_SAMPLE_CYC - 1));

   // Inputs as the host sees them: index 8-11, A 12-15, B 16-19.
   wire [11:0]       enc_raw  = {encoder_phase_b, encoder_phase_a, encoder_index};
   wire [19:0]       din_now  = {filt_q, dedicated_input}; // RULE17 RULE18

   // Read data selection; returns are latched in the setup cycle.
   logic [31:0]      rd_data;
   always_comb begin
      rd_data = 32'h0;
      if (hit_ctrl) begin
         rd_data[11:0] = ctrl_q;
      end else if (hit_dout) begin
         rd_data[17:0] = dout_q;
      end else if (hit_flip) begin
         rd_data[17:0] = flip_q;
      end else if (hit_din) begin
         rd_data[19:0] = din_now; // RULE21
      end else if (hit_stat) begin
         rd_data[1:0] = {pins_en, wd_exp_q};
      end else if (hit_cnt) begin
         rd_data[CNT_W-1:0]   = cnt_w[ch_sel];
         rd_data[`SRVQ_B_IDX] = idx_w[ch_sel];
      end
   end

   // Per-channel strobes.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         duty_we[c] = wr_en & hit_duty & (ch_sel == 2'(c));
         idx_clr[c] = ce & setup & ~apb_req.pwrite & hit_cnt & (ch_sel == 2'(c));
      end
   end

   // Bus response: ready in the first access cycle, data and error from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit;
         if (setup) begin
            prdata_q <= rd_data;
         end
      end
   end

   // Writable configuration; dedicated outputs change together.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SRVQ_CTRL_RST;
         dout_q <= 18'h0;
         flip_q <= 18'h0;
      end else if (ce && wr_en) begin
         if (hit_ctrl) begin
            ctrl_q <= apb_req.pwdata[11:0];
         end
         if (hit_dout) begin
            dout_q <= apb_req.pwdata[17:0]; // RULE14 RULE20
         end
         if (hit_flip) begin
            flip_q <= apb_req.pwdata[17:0];
         end
      end
   end

   // Watchdog: every write restarts it; expiry holds until the next write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_cnt_q <= '0;
         wd_exp_q <= 1'b0;
      end else if (ce) begin
         if (wr_en) begin
            wd_cnt_q <= '0; // RULE23
            wd_exp_q <= 1'b0;
         end else if (wd_en && !wd_exp_q) begin
            if (wd_cnt_q == WDW'(WD_CYCLES - 1)) begin
               wd_exp_q <= 1'b1; // RULE1
            end else begin
               wd_cnt_q <= wd_cnt_q + 1'b1;
            end
         end
      end
   end

   // Sample tick and shared PWM period counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcnt_q <= '0;
         pcnt_q <= 11'h0;
      end else if (ce) begin
         tcnt_q <= tick ? '0 : tcnt_q + 1'b1; // RULE5
         pcnt_q <= (pcnt_q == `SRVQ_PWM_PERIOD - 11'h1) ? 11'h0 : pcnt_q + 11'h1; // RULE10
      end
   end

   // Glitch filters: a level must hold for seven samples before it is taken.
   for (genvar i = 0; i < 12; i++) begin : g_filt
      logic [2:0] fcnt_q;
      logic       filt_bit_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fcnt_q     <= 3'h0;
            filt_bit_q <= 1'b0;
         end else if (ce && tick) begin
            if (enc_raw[i] == filt_bit_q) begin
               fcnt_q <= 3'h0;
            end else if (fcnt_q == `SRVQ_FILT_N - 3'h1) begin
               fcnt_q     <= 3'h0; // RULE5
               filt_bit_q <= enc_raw[i];
            end else begin
               fcnt_q <= fcnt_q + 3'h1;
            end
         end
      end
      // Each filter owns one bit of the shared filtered vector.
      assign filt_q[i] = filt_bit_q;
      assign fcnt_w[i] = fcnt_q;
   end

   // Channels: quadrature counter, index event, duty register and PWM.
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic             a_p_q;
      logic             b_p_q;
      logic             z_p_q;
      logic [CNT_W-1:0] cnt_q;
      logic             idx_q;
      logic [11:0]      duty_q;
      logic [1:0]       sh_q;
      logic [10:0]      acc_q;
      logic             pdm_q;
      wire              fa    = filt_q[4 + c];
      wire              fb    = filt_q[8 + c];
      wire              fz    = filt_q[c];
      wire              step  = (fa ^ a_p_q) ^ (fb ^ b_p_q); // RULE7
      wire              up    = fa ^ b_p_q;
      wire              neg   = duty_q[11];
      wire [11:0]       absd  = neg ? 12'h0 - duty_q : duty_q;
      wire [10:0]       mag   = absd[10:0]; // RULE9
      wire [11:0]       acc_s = {1'b0, acc_q} + {1'b0, mag};
      wire              pdm_c = (acc_s >= {1'b0, `SRVQ_PWM_PERIOD});
      wire              pwm   = pdm[c] ? pdm_q : (pcnt_q < mag); // RULE11
      wire              upsig = pds[c] ? pwm : (pwm & ~neg); // RULE12
      wire              dnsig = pds[c] ? neg : (pwm & neg); // RULE3 RULE13
      wire [11:0]       wdat  = apb_req.pwdata[11:0];

      // Edge decode at each sample, free-running wrap, sticky index event.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            a_p_q <= 1'b0;
            b_p_q <= 1'b0;
            z_p_q <= 1'b0;
            cnt_q <= '0;
            idx_q <= 1'b0;
         end else if (ce) begin
            if (tick) begin
               a_p_q <= fa;
               b_p_q <= fb;
               z_p_q <= fz;
               if (step) begin
                  cnt_q <= up ? cnt_q + 1'b1 : cnt_q - 1'b1; // RULE7 RULE8 RULE22
               end
            end
            if (tick && fz && !z_p_q) begin
               idx_q <= 1'b1; // RULE4
            end else if (idx_clr[c]) begin
               idx_q <= 1'b0;
            end
         end
      end

      // Duty write, shared outputs taken with it, and pulse-density accumulator.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            duty_q <= 12'h0;
            sh_q   <= 2'h0;
            acc_q  <= 11'h0;
            pdm_q  <= 1'b0;
         end else if (ce) begin
            if (duty_we[c]) begin
               duty_q <= (wdat == 12'h800) ? 12'h801 : wdat; // RULE9
               sh_q   <= dout_q[10 + 2*c +: 2]; // RULE20
            end
            acc_q <= pdm_c ? 11'(acc_s - {1'b0, `SRVQ_PWM_PERIOD}) : acc_s[10:0];
            pdm_q <= pdm_c;
         end
      end

      assign cnt_w[c] = cnt_q;
      assign idx_w[c] = idx_q;
      assign neg_w[c] = neg;
      assign inc_w[c] = upsig ^ sh_q[0] ^ flip_q[10 + 2*c]; // RULE15 RULE16
      assign dec_w[c] = dnsig ^ sh_q[1] ^ flip_q[11 + 2*c]; // RULE3 RULE15 RULE16
   end

   // Pin values and enables, registered so every pin comes from a flop.
   assign pins_d = '{led:  inc_w[0] ^ dec_w[0], // RULE6
                     dout: dout_q[9:0] ^ flip_q[9:0],
                     dec:  dec_w,
                     inc:  inc_w};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_q    <= '0;
         pins_oe_q <= '0; // RULE2
      end else if (ce) begin
         pins_q    <= pins_d;
         pins_oe_q <= {$bits(srvq_pins_t){pins_en}}; // RULE1 RULE2
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign pins    = pins_q;
   assign pins_oe = pins_oe_q;

   // Checks.
   property p_wd_release;
      @(posedge pclk) disable iff (!presetn)
      (ce && wd_en && wd_exp_q) |=> (pins_oe_q == '0);
   endproperty
   a_wd_release: assert property (p_wd_release) else $error("pins driven after watchdog expiry"); // RULE1

   property p_unconfigured;
      @(posedge pclk) disable iff (!presetn)
      (ce && !out_en) |=> (pins_oe_q == '0);
   endproperty
   a_unconfigured: assert property (p_unconfigured) else $error("pins driven while outputs disabled"); // RULE2

   property p_dir;
      @(posedge pclk) disable iff (!presetn)
      (ce && pds[0] && !flip_q[11] && !g_ch[0].sh_q[1]) |=> (pins_q.dec[0] == $past(neg_w[0]));
   endproperty
   a_dir: assert property (p_dir) else $error("direction pin does not follow duty sign"); // RULE3

   property p_index;
      @(posedge pclk) disable iff (!presetn)
      (ce && tick && filt_q[0] && !g_ch[0].z_p_q) |=> idx_w[0];
   endproperty
   a_index: assert property (p_index) else $error("index rising edge not recorded"); // RULE4

   property p_filter;
      @(posedge pclk) disable iff (!presetn)
      (ce && tick && fcnt_w[0] != `SRVQ_FILT_N - 3'h1) |=> (filt_q[0] == $past(filt_q[0]));
   endproperty
   a_filter: assert property (p_filter) else $error("filter passed a short pulse"); // RULE5

   property p_led;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |-> (pins_q.led == (pins_q.inc[0] ^ pins_q.dec[0]));
   endproperty
   a_led: assert property (p_led) else $error("led differs from channel 0 xor"); // RULE6

   property p_period;
      @(posedge pclk) disable iff (!presetn)
      (ce && pcnt_q == 11'h7fe) |=> (pcnt_q == 11'h0);
   endproperty
   a_period: assert property (p_period) else $error("pwm period is not 2047 cycles"); // RULE10

   property p_din_latch;
      @(posedge pclk) disable iff (!presetn)
      (ce && setup && hit_din) |=> (prdata_q[19:0] == $past(din_now));
   endproperty
   a_din_latch: assert property (p_din_latch) else $error("inputs not latched together"); // RULE21

   property p_wd_restart;
      @(posedge pclk) disable iff (!presetn)
      (ce && wr_en) |=> (wd_cnt_q == '0 && !wd_exp_q);
   endproperty
   a_wd_restart: assert property (p_wd_restart) else $error("write did not restart watchdog"); // RULE23

   property p_ready_once;
      @(posedge pclk) disable iff (!presetn)
      (ce && apb_req.psel && apb_req.penable && pready_q) |=> !pready_q;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held past the access cycle"); // RULE19

   property p_pwm_inc;
      @(posedge pclk) disable iff (!presetn)
      (ce && pds[0] && !pdm[0] && !flip_q[10] && !g_ch[0].sh_q[0]) |=>
         (pins_q.inc[0] == ($past(pcnt_q) < $past(g_ch[0].mag)));
   endproperty
   a_pwm_inc: assert property (p_pwm_inc) else $error("pulse pin does not carry the pwm"); // RULE12

   property p_updown_dec;
      @(posedge pclk) disable iff (!presetn)
      (ce && !pds[0] && !pdm[0] && !flip_q[11] && !g_ch[0].sh_q[1]) |=>
         (pins_q.dec[0] == ($past(g_ch[0].neg) && ($past(pcnt_q) < $past(g_ch[0].mag))));
   endproperty
   a_updown_dec: assert property (p_updown_dec) else $error("down pin does not carry the down signal"); // RULE13

   property p_count_step;
      @(posedge pclk) disable iff (!presetn)
      (ce && tick && g_ch[0].step) |=> (cnt_w[0] != $past(cnt_w[0]));
   endproperty
   a_count_step: assert property (p_count_step) else $error("phase edge not counted"); // RULE7

   property p_shared_hold;
      @(posedge pclk) disable iff (!presetn)
      (ce && !duty_we[0]) |=> (g_ch[0].sh_q == $past(g_ch[0].sh_q));
   endproperty
   a_shared_hold: assert property (p_shared_hold) else $error("shared outputs changed without a duty write"); // RULE20

endmodule // srvq_top

//--- testbench/srvq_enc_model.sv
// Behavioural quadrature encoder that drives the four encoder channels of the block.
`timescale 1ns/1ps
module srvq_enc_model (
   // Clock.
   input  wire logic pclk,
   // Encoder pins.
   output logic [3:0] phase_a,
   output logic [3:0] phase_b,
   output logic [3:0] index
);
   int pos [4];

   // Pins start low with every channel in state zero.
   initial begin
      phase_a = 4'h0;
      phase_b = 4'h0;
      index = 4'h0;
      foreach (pos[i]) pos[i] = 0;
   end

   // Moves one channel a single Gray step, phase A leading when dir is +1.
   task automatic step(input int ch, input int dir, input int hold);
      logic [1:0] ab;
      pos[ch] = (pos[ch] + dir) & 3;
      ab = (pos[ch] == 0) ? 2'h0 : (pos[ch] == 1) ? 2'h2 : (pos[ch] == 2) ? 2'h3 : 2'h1;
      @(posedge pclk);
      phase_a[ch] <= ab[1];
      phase_b[ch] <= ab[0];
      repeat (hold) @(posedge pclk);
   endtask

   // Flips phase A or raises the index of one channel for len cycles, then restores it.
   task automatic pulse(input int ch, input bit on_index, input int len);
      @(posedge pclk);
      if (on_index) index[ch] <= 1'b1;
      else phase_a[ch] <= ~phase_a[ch];
      repeat (len) @(posedge pclk);
      if (on_index) index[ch] <= 1'b0;
      else phase_a[ch] <= ~phase_a[ch];
      repeat (40) @(posedge pclk);
   endtask

   // Sets every level at once and waits for the input filter to settle.
   task automatic set_lvl(input logic [3:0] a, input logic [3:0] b, input logic [3:0] z);
      @(posedge pclk);
      phase_a <= a;
      phase_b <= b;
      index <= z;
      repeat (40) @(posedge pclk);
   endtask
endmodule // srvq_enc_model

//--- testbench/tb_servo_pwm_quadrature_io.sv
// Self-checking testbench of the servo PWM and quadrature block over its APB port.
`timescale 1ns/1ps
`include "srvq_regs.svh"
module tb_servo_pwm_quadrature_io;
   import srvq_pkg::*;
`define CHK(g, e) check(32'(g), 32'(e))
   logic          pclk;
   logic          presetn;
   logic          ce;
   srvq_apb_req_t req;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic [7:0]    din;
   logic [3:0]    qa;
   logic [3:0]    qb;
   logic [3:0]    qz;
   srvq_pins_t    pins;
   srvq_pins_t    pins_oe;
   int            n_mismatch = 0;
   int            checks_done = 0;
   int            led_bad = 0;
   int            hi_i;
   int            hi_d;
   int            rises;
   localparam logic [31:0] PW_CTRL [7] = '{32'h1, 32'h1, 32'h11, 32'h11, 32'h11, 32'h1, 32'h11};
   localparam logic [31:0] PW_FLIP [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h800};
   localparam logic [31:0] PW_DUTY [7] = '{32'h64, 32'hf9c, 32'hf9c, 32'h7ff, 32'h800, 32'h0, 32'hf9c};
   localparam int          PW_INC [7]  = '{100, 0, 100, 2047, 2047, 0, 100};
   localparam int          PW_DEC [7]  = '{0, 100, 2047, 0, 2047, 0, 0};

   // The clock toggles every 4 ns for 125 MHz.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   srvq_top #(.WD_CYCLES(50)) srvq_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dedicated_input(din), .encoder_phase_a(qa),
      .encoder_phase_b(qb), .encoder_index(qz), .pins(pins), .pins_oe(pins_oe));
   srvq_enc_model srvq_enc_model_inst (.pclk(pclk), .phase_a(qa), .phase_b(qb), .index(qz));

   // Compares one value and counts it.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge pclk);
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= wd;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      @(posedge pclk);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (i >= 20) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   // Register write.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   // Register read compared with the expected data and error flag.
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, exp);
      `CHK(e, experr);
   endtask

   // Counts high cycles of channel 0 pins and rising edges of its increase pin while watching the LED.
   task automatic measure(input int n);
      logic p;
      hi_i = 0;
      hi_d = 0;
      rises = 0;
      p = pins.inc[0];
      repeat (n) begin
         @(posedge pclk);
         #1;
         if (pins.inc[0] === 1'b1) hi_i++;
         if (pins.dec[0] === 1'b1) hi_d++;
         if (pins.inc[0] === 1'b1 && p === 1'b0) rises++;
         if (pins.led !== (pins.inc[0] ^ pins.dec[0])) led_bad++;
         p = pins.inc[0];
      end
   endtask

   // Main sequence.
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      req = '0;
      din = 8'ha5;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      `CHK(pins_oe, 19'h0);
      rd(`SRVQ_A_CTRL, `SRVQ_CTRL_RST, 1'b0);
      rd(12'h0fc, 32'h0, 1'b1);
      $display("test reset done");
      wr(`SRVQ_A_CTRL, 32'h1);
      wr(`SRVQ_A_DOUT, 32'h2a5);
      repeat (2) @(posedge pclk);
      `CHK(pins.dout, 10'h2a5);
      `CHK(pins_oe, 19'h7ffff);
      wr(`SRVQ_A_DOUT, 32'h3fc00);
      repeat (3) @(posedge pclk);
      `CHK({pins.inc, pins.dec}, 8'h0);
      wr(`SRVQ_A_DUTY, 32'h0);
      repeat (3) @(posedge pclk);
      `CHK({pins.inc, pins.dec}, 8'h11);
      for (int c = 1; c < 4; c++) wr(12'(`SRVQ_A_DUTY + 4 * c), 32'h0);
      repeat (3) @(posedge pclk);
      `CHK({pins.inc, pins.dec}, 8'hff);
      wr(`SRVQ_A_FLIP, 32'hc00);
      wr(`SRVQ_A_DUTY, 32'h0);
      repeat (3) @(posedge pclk);
      `CHK({pins.inc, pins.dec}, 8'hee);
      wr(`SRVQ_A_DOUT, 32'h0);
      $display("test outputs done");
      for (int t = 0; t < 7; t++) begin
         wr(`SRVQ_A_CTRL, PW_CTRL[t]);
         wr(`SRVQ_A_FLIP, PW_FLIP[t]);
         wr(`SRVQ_A_DUTY, PW_DUTY[t]);
         repeat (2100) @(posedge pclk);
         measure(2047);
         `CHK(hi_i, PW_INC[t]);
         `CHK(hi_d, PW_DEC[t]);
      end
      `CHK(led_bad, 0);
      wr(`SRVQ_A_CTRL, 32'h101);
      wr(`SRVQ_A_FLIP, 32'h0);
      wr(`SRVQ_A_DUTY, 32'h3ff);
      repeat (2100) @(posedge pclk);
      measure(2047);
      `CHK(hi_i >= 1022 && hi_i <= 1024, 1'b1);
      `CHK(rises > 500, 1'b1);
      wr(`SRVQ_A_DUTY, 32'h0);
      wr(`SRVQ_A_CTRL, 32'h1);
      $display("test pwm done");
      rd(`SRVQ_A_COUNT, 32'h0, 1'b0);
      repeat (10) srvq_enc_model_inst.step(0, 1, 30);
      repeat (40) @(posedge pclk);
      rd(`SRVQ_A_COUNT, 32'ha, 1'b0);
      repeat (15) srvq_enc_model_inst.step(0, -1, 30);
      repeat (40) @(posedge pclk);
      rd(`SRVQ_A_COUNT, 32'h3ffb, 1'b0);
      srvq_enc_model_inst.pulse(0, 1'b0, 15);
      rd(`SRVQ_A_COUNT, 32'h3ffb, 1'b0);
      srvq_enc_model_inst.pulse(1, 1'b1, 60);
      rd(12'(`SRVQ_A_COUNT + 4), 32'h10000, 1'b0);
      rd(12'(`SRVQ_A_COUNT + 4), 32'h0, 1'b0);
      srvq_enc_model_inst.pulse(1, 1'b1, 15);
      rd(12'(`SRVQ_A_COUNT + 4), 32'h0, 1'b0);
      din <= 8'h3c;
      srvq_enc_model_inst.set_lvl(4'h5, 4'h3, 4'h9);
      rd(`SRVQ_A_DIN, 32'h3593c, 1'b0);
      $display("test encoder done");
      wr(`SRVQ_A_CTRL, 32'h3);
      repeat (4) begin
         repeat (30) @(posedge pclk);
         wr(`SRVQ_A_DOUT, 32'h0);
      end
      `CHK(pins_oe, 19'h7ffff);
      repeat (70) @(posedge pclk);
      `CHK(pins_oe, 19'h0);
      rd(`SRVQ_A_STAT, 32'h1, 1'b0);
      wr(`SRVQ_A_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      `CHK(pins_oe, 19'h7ffff);
      wr(`SRVQ_A_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      `CHK(pins_oe, 19'h0);
      $display("test watchdog done");
      stop_test();
   end
endmodule // tb_servo_pwm_quadrature_io
